//--- dv/reset_sequence_control_tb_top.sv
// Purpose: self-checking bench of the reset sequence controller
// Assumes: all phases shortened to 4 cycles
// Notes: registers mirrored in an integer model; far side lives in rsc_partner
module reset_sequence_control_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import reset_seq_pkg::*;
	localparam int PH = 4;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	axil_req_s req = '0;
	axil_rsp_s rsp;
	logic ext_reg = 1'b0;
	logic dest_ev = 1'b0;
	logic func_ev = 1'b0;
	logic func_long = 1'b0;
	logic [2:0] src = 3'h0;
	logic supply_ok = 1'b0;
	logic hold_low = 1'b0;
	logic [7:0] test_delay = 8'h01;
	logic por_n, pin_in, test_done, pin_out, oe_n, test_start, bist, run_entry, fetch, low_det_en, high_det_en;
	logic saw_bist, saw_start, saw_low, saw_run;
	logic [31:0] rd;
	logic [1:0] resp;
	int miscompares = 0;
	int num_checks = 0;
	int cycles = 0;
	int seed = 58474;
	int model [4];

	reset_sequence_control #(.PH1_CYC(PH), .PH2_CYC(PH), .PH3_CYC(PH), .BIST_CYC(PH)) dut_u (
		.sys_clk(sys_clk), .nrst(nrst), .axil_req(req), .axil_rsp(rsp),
		.regulator_power_on_reset_n(por_n), .external_regulation(ext_reg),
		.destructive_event(dest_ev), .functional_event(func_ev), .functional_long(func_long),
		.functional_source(src), .switching_regulator_test_done(test_done), .reset_pin_in(pin_in),
		.reset_pin_out(pin_out), .reset_pin_oe_n(oe_n), .switching_regulator_test_start(test_start),
		.bist_active(bist), .run_mode_entry(run_entry), .fetch_enable(fetch),
		.low_voltage_detector_en(low_det_en), .high_voltage_detector_en(high_det_en));

	rsc_partner partner_u (
		.sys_clk(sys_clk), .supply_ok(supply_ok), .hold_low(hold_low), .test_delay(test_delay),
		.reset_pin_oe_n(oe_n), .switching_regulator_test_start(test_start),
		.regulator_power_on_reset_n(por_n), .reset_pin_in(pin_in), .switching_regulator_test_done(test_done));

	always #10 sys_clk = ~sys_clk;

	// outputs are settled mid-cycle, so the monitor looks on the falling edge
	always @(negedge sys_clk) begin
		saw_bist |= (bist === 1'b1);
		saw_start |= (test_start === 1'b1);
		saw_low |= (oe_n === 1'b0);
		saw_run |= (run_entry === 1'b1);
	end

	task automatic print_verdict();
		$display("checks=%0d miscompares=%0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			print_verdict();
		end
	end

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp);
		chk_reg({31'h0, got}, {31'h0, exp});
	endtask

	task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tr, td;
		@(posedge sys_clk);
		if (wr) begin
			req.awvalid <= 1'b1;
			req.awaddr <= a;
			req.wvalid <= 1'b1;
			req.wdata <= d;
			req.wstrb <= 4'hF;
			req.bready <= 1'b1;
		end else begin
			req.arvalid <= 1'b1;
			req.araddr <= a;
			req.rready <= 1'b1;
		end
		// no wait limit of its own: only the bench timeout ends a hung transfer
		forever begin
			@(negedge sys_clk);
			ta = req.awvalid && rsp.awready;
			tw = req.wvalid && rsp.wready;
			tr = req.arvalid && rsp.arready;
			td = wr ? rsp.bvalid : rsp.rvalid;
			resp = wr ? rsp.bresp : rsp.rresp;
			rd = rsp.rdata;
			@(posedge sys_clk);
			if (ta)
				req.awvalid <= 1'b0;
			if (tw)
				req.wvalid <= 1'b0;
			if (tr)
				req.arvalid <= 1'b0;
			if (td)
				break;
		end
		req.bready <= 1'b0;
		req.rready <= 1'b0;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		axi(1'b1, a, d);
		chk_reg({30'h0, resp}, (a < 8'h10) ? 32'h0 : 32'h2);
		if (a < 8'h0C)
			model[a[3:2]] = d;
	endtask

	task automatic rd_reg(input logic [7:0] a);
		axi(1'b0, a, 32'h0);
		chk_reg({30'h0, resp}, (a < 8'h10) ? 32'h0 : 32'h2);
		chk_reg(rd, (a < 8'h10) ? model[a[3:2]] : 32'h0);
	endtask

	task automatic do_reset(input logic ext);
		@(posedge sys_clk);
		nrst <= 1'b0;
		supply_ok <= 1'b0;
		ext_reg <= ext;
		repeat (8) @(posedge sys_clk);
		nrst <= 1'b1;
		model = '{32'h1, 32'hFFFF_FFFF, ext ? 0 : 3, 0};
		repeat (4) @(posedge sys_clk);
		supply_ok <= 1'b1;
	endtask

	// go: bit0 destructive, bit1 functional, bit2 outside generator pulls the pin
	task automatic seq(input logic [2:0] go, input logic fl, input logic [2:0] s, input int hold,
			input logic eb, input logic es, input logic el);
		saw_bist = 1'b0;
		saw_start = 1'b0;
		saw_low = 1'b0;
		saw_run = 1'b0;
		@(posedge sys_clk);
		dest_ev <= go[0];
		func_ev <= go[1];
		hold_low <= go[2];
		func_long <= fl;
		src <= s;
		@(posedge sys_clk);
		dest_ev <= 1'b0;
		func_ev <= 1'b0;
		if (hold > 0) begin
			repeat (hold) @(posedge sys_clk);
			@(negedge sys_clk);
			chk_flag(fetch, 1'b0);
			chk_flag(oe_n, 1'b1);
			chk_flag(pin_in, 1'b0);
			@(posedge sys_clk);
			hold_low <= 1'b0;
		end
		repeat (300) begin
			@(negedge sys_clk);
			if (saw_run)
				break;
		end
		chk_flag(saw_run, 1'b1);
		chk_flag(fetch, 1'b1);
		chk_flag(saw_bist, eb);
		chk_flag(saw_start, es);
		chk_flag(saw_low, el);
		chk_flag(pin_out, 1'b0);
	endtask

	initial begin
		logic [31:0] m;
		do_reset(1'b0);
		@(negedge sys_clk);
		chk_flag(oe_n, 1'b0);
		seq(3'h0, 1'b0, 3'h0, 0, 1'b1, 1'b1, 1'b1);
		rd_reg(8'h00);
		rd_reg(8'h04);
		rd_reg(8'h08);
		@(negedge sys_clk);
		chk_flag(low_det_en & high_det_en, 1'b1);
		rd_reg(8'h10);
		wr_reg(8'h14, 32'h0000_0005);
		m = $random(seed);
		m[1:0] = 2'h2;
		wr_reg(8'h04, m);
		rd_reg(8'h04);
		for (int i = 0; i < 8; i++) begin
			seq(3'h2, i[0], i[2:0], 0, 1'b0, 1'b0, model[1][i]);
		end
		wr_reg(8'h00, 32'h0);
		@(posedge sys_clk);
		test_delay <= 8'h0C;
		seq(3'h1, 1'b0, 3'h0, 0, 1'b0, 1'b1, 1'b1);
		wr_reg(8'h00, 32'h1);
		seq(3'h1, 1'b0, 3'h0, 0, 1'b1, 1'b1, 1'b1);
		seq(3'h4, 1'b0, 3'h0, 60, 1'b1, 1'b0, 1'b1);
		do_reset(1'b1);
		seq(3'h0, 1'b0, 3'h0, 0, 1'b1, 1'b1, 1'b1);
		rd_reg(8'h08);
		@(negedge sys_clk);
		chk_flag(low_det_en | high_det_en, 1'b0);
		wr_reg(8'h08, 32'h3);
		@(negedge sys_clk);
		chk_flag(low_det_en & high_det_en, 1'b1);
		// status is read only: a write is answered but leaves it alone
		m = $random(seed);
		wr_reg(8'h0C, m);
		// run state, destructive kind with self test, pin high
		model[3] = 32'h0004_0040;
		rd_reg(8'h0C);
		print_verdict();
	end
endmodule

//--- dv/rsc_partner.sv
// Purpose: far side of the reset controller: power chip, reset generator, pull-up, regulator self test
// Assumes: one clock; the reset pin has an external pull-up
// Notes: test_delay sets how slowly the self test answers
module rsc_partner (
	input wire logic sys_clk,
	input wire logic supply_ok,
	input wire logic hold_low,
	input wire logic [7:0] test_delay,
	input wire logic reset_pin_oe_n,
	input wire logic switching_regulator_test_start,
	output logic regulator_power_on_reset_n,
	output logic reset_pin_in,
	output logic switching_regulator_test_done
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = -1;
	logic [1:0] ok_dly = 2'h0;
	// wired-and of the open-drain drivers; nobody drives high, the pull-up wins when all let go
	assign reset_pin_in = reset_pin_oe_n & ~hold_low;
	// supplies must stay in range a while before the power-on reset is let go
	assign regulator_power_on_reset_n = ok_dly[1];
	always @(posedge sys_clk) begin
		ok_dly <= {ok_dly[0], supply_ok};
		switching_regulator_test_done <= (cnt == 0);
		if (switching_regulator_test_start)
			cnt <= int'(test_delay);
		else if (cnt >= 0)
			cnt <= cnt - 1;
	end
endmodule

//--- hdl/phase_timer.sv
// Purpose: down counter that times one reset phase
// Assumes: load and value are registered by the caller
// Notes: expired is high while the count is zero and no load is pending
module phase_timer #(
	parameter int W = 24
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic load,
	input wire logic [W-1:0] value,
	output logic expired
);
	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;

	always_comb begin
		next_cnt = cnt;
		if (load) begin
			next_cnt = value;
		end else if (cnt != '0) begin
			next_cnt = cnt - 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end

	assign expired = (cnt == '0) && !load;
endmodule

//--- hdl/reset_sequence_control.sv
// Purpose: reset sequence controller with open-drain reset pin and AXI4-Lite registers
// Assumes: all inputs synchronous to sys_clk
// Notes: the pin is open drain; oe_n low means the pin is pulled low
`include "reset_seq_defines.svh"
module reset_sequence_control #(
	parameter int NSRC = 8,
	parameter int W = 24,
	parameter int PH1_CYC = `RSC_PH1_CYC,
	parameter int PH2_CYC = `RSC_PH2_CYC,
	parameter int PH3_CYC = `RSC_PH3_CYC,
	parameter int BIST_CYC = `RSC_BIST_CYC
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input reset_seq_pkg::axil_req_s axil_req,
	output reset_seq_pkg::axil_rsp_s axil_rsp,
	input wire logic regulator_power_on_reset_n,
	input wire logic external_regulation,
	input wire logic destructive_event,
	input wire logic functional_event,
	input wire logic functional_long,
	input wire logic [$clog2(NSRC)-1:0] functional_source,
	input wire logic switching_regulator_test_done,
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe_n,
	output logic switching_regulator_test_start,
	output logic bist_active,
	output logic run_mode_entry,
	output logic fetch_enable,
	output logic low_voltage_detector_en,
	output logic high_voltage_detector_en
);
	import reset_seq_pkg::*;

	// a single source would leave the source index without bits; wide timers overflow the shift
	if (NSRC < 2 || NSRC > 32 || W < 2 || W > 30 || PH1_CYC < 1 || PH2_CYC < 1 || PH3_CYC < 1 || BIST_CYC < 1 ||
	    PH1_CYC >= (1 << W) || PH2_CYC >= (1 << W) || PH3_CYC >= (1 << W) ||
	    BIST_CYC >= (1 << W)) begin : g_bad_param
		$error("reset_sequence_control: parameter out of range");
	end

	// ------------------------------------------------------------
	// sequence state
	// ------------------------------------------------------------
	seq_state_e state, next_state;
	seq_kind_e kind, next_kind;
	logic [$clog2(NSRC)-1:0] src, next_src;
	logic oe_n, next_oe_n;
	logic regtest_start, next_regtest_start;
	logic regtest_ok, next_regtest_ok;
	logic run_pulse, next_run_pulse;
	logic tmr_load, next_tmr_load;
	logic [W-1:0] tmr_value, next_tmr_value;
	logic expired;
	logic ctrl_bist;
	logic [NSRC-1:0] pin_en;
	logic is_func;
	logic uses_bist;

	phase_timer #(.W(W)) u_timer (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.load(tmr_load),
		.value(tmr_value),
		.expired(expired)
	);

	assign is_func = (kind == K_FUNC_LONG) || (kind == K_FUNC_SHORT);
	assign uses_bist = (kind == K_DEST_BIST) || (kind == K_EXT_LONG);

	always_comb begin
		next_state = state;
		next_kind = kind;
		next_src = src;
		next_regtest_ok = regtest_ok || switching_regulator_test_done;
		if (!regulator_power_on_reset_n) begin
			// supplies are trusted in range once the input is released
			next_state = ST_POR;
			next_kind = K_DEST;
		end else if (state == ST_POR || destructive_event) begin
			next_state = ST_PH1;
			next_kind = ctrl_bist ? K_DEST_BIST : K_DEST;
		end else begin
			case (state)
				ST_PH1: begin
					if (expired) begin
						next_state = (kind == K_FUNC_SHORT) ? ST_PH3 : ST_PH2;
					end
				end
				ST_PH2: begin
					if (expired) begin
						next_state = uses_bist ? ST_BIST : ST_PH3;
					end
				end
				ST_BIST: begin
					if (expired) begin
						next_state = ST_PH3;
					end
				end
				ST_PH3: begin
					// destructive sequences wait for the regulator test inside this phase
					if (expired && (is_func || kind == K_EXT_LONG || regtest_ok)) begin
						next_state = ST_EXTEND;
					end
				end
				ST_EXTEND: begin
					if (reset_pin_in) begin
						next_state = ST_RUN;
					end
				end
				ST_RUN: begin
					if (!reset_pin_in) begin
						next_state = ST_PH1;
						next_kind = K_EXT_LONG;
					end else if (functional_event) begin
						next_state = ST_PH1;
						next_kind = functional_long ? K_FUNC_LONG : K_FUNC_SHORT;
						next_src = functional_source;
					end
				end
				default: begin
					next_state = ST_POR;
				end
			endcase
		end
		if (next_state != ST_PH3) begin
			next_regtest_ok = 1'b0;
		end
		next_regtest_start = (next_state == ST_PH3) && (state != ST_PH3) &&
			(next_kind == K_DEST || next_kind == K_DEST_BIST);
		next_run_pulse = (next_state == ST_RUN) && (state != ST_RUN);
		// a destructive event inside phase one must restart its count as well
		next_tmr_load = (next_state != state) || (next_kind != kind) ||
			(regulator_power_on_reset_n && destructive_event);
		case (next_state)
			ST_PH1: next_tmr_value = W'(PH1_CYC);
			ST_PH2: next_tmr_value = W'(PH2_CYC);
			ST_BIST: next_tmr_value = W'(BIST_CYC);
			ST_PH3: next_tmr_value = W'(PH3_CYC);
			default: next_tmr_value = '0;
		endcase
		// the pin is released at the end of the third phase, or never pulled for a masked source
		if (next_state == ST_EXTEND || next_state == ST_RUN) begin
			next_oe_n = 1'b1;
		end else if (next_kind == K_FUNC_LONG || next_kind == K_FUNC_SHORT) begin
			next_oe_n = !pin_en[next_src];
		end else begin
			next_oe_n = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_POR;
			kind <= K_DEST;
			src <= '0;
			oe_n <= 1'b0;
			regtest_start <= 1'b0;
			regtest_ok <= 1'b0;
			run_pulse <= 1'b0;
			tmr_load <= 1'b0;
			tmr_value <= '0;
		end else begin
			state <= next_state;
			kind <= next_kind;
			src <= next_src;
			oe_n <= next_oe_n;
			regtest_start <= next_regtest_start;
			regtest_ok <= next_regtest_ok;
			run_pulse <= next_run_pulse;
			tmr_load <= next_tmr_load;
			tmr_value <= next_tmr_value;
		end
	end

	assign reset_pin_out = 1'b0;
	assign reset_pin_oe_n = oe_n;
	assign switching_regulator_test_start = regtest_start;
	assign bist_active = (state == ST_BIST);
	assign run_mode_entry = run_pulse;
	assign fetch_enable = (state == ST_RUN);

	// ------------------------------------------------------------
	// registers and AXI4-Lite slave
	// ------------------------------------------------------------
	logic [31:0] ctrl, next_ctrl;
	logic [31:0] pin_en_reg, next_pin_en_reg;
	logic [1:0] vdet, next_vdet;
	logic boot_done;
	logic aw_hold, next_aw_hold;
	logic w_hold, next_w_hold;
	logic [7:0] waddr, next_waddr;
	logic [31:0] wdata, next_wdata;
	logic [3:0] wstrb, next_wstrb;
	logic bvalid, next_bvalid;
	logic [1:0] bresp, next_bresp;
	logic rvalid, next_rvalid;
	logic [31:0] rdata, next_rdata;
	logic [1:0] rresp, next_rresp;
	logic [31:0] wmask;
	logic [31:0] status;
	logic do_write;

	assign ctrl_bist = ctrl[`RSC_CTRL_BIST_BIT];
	assign pin_en = pin_en_reg[NSRC-1:0];
	assign status = {12'h000, 1'b0, reset_pin_in, 2'h0, 5'h00, kind, 1'b0, state};
	assign do_write = (aw_hold || axil_req.awvalid) && (w_hold || axil_req.wvalid) && !bvalid;

	always_comb begin
		next_aw_hold = aw_hold;
		next_w_hold = w_hold;
		next_waddr = waddr;
		next_wdata = wdata;
		next_wstrb = wstrb;
		next_bvalid = bvalid && !axil_req.bready;
		next_bresp = bresp;
		next_ctrl = ctrl;
		next_pin_en_reg = pin_en_reg;
		next_vdet = vdet;
		next_rvalid = rvalid && !axil_req.rready;
		next_rdata = rdata;
		next_rresp = rresp;
		wmask = '0;
		if (!boot_done) begin
			// detectors would fight an outside regulator, so they start off there
			next_vdet = external_regulation ? `RSC_VDET_OFF : `RSC_VDET_ON;
		end
		if (axil_req.awvalid && !aw_hold && !bvalid) begin
			next_aw_hold = 1'b1;
			next_waddr = axil_req.awaddr;
		end
		if (axil_req.wvalid && !w_hold && !bvalid) begin
			next_w_hold = 1'b1;
			next_wdata = axil_req.wdata;
			next_wstrb = axil_req.wstrb;
		end
		if (do_write) begin
			next_aw_hold = 1'b0;
			next_w_hold = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = 2'h0;
			for (int i = 0; i < 4; i++) begin
				wmask[i*8 +: 8] = {8{next_wstrb[i]}};
			end
			if (next_waddr == `RSC_OFS_CTRL) begin
				next_ctrl = (ctrl & ~wmask) | (next_wdata & wmask & 32'h0000_0001);
			end else if (next_waddr == `RSC_OFS_PIN_EN) begin
				next_pin_en_reg = (pin_en_reg & ~wmask) | (next_wdata & wmask);
			end else if (next_waddr == `RSC_OFS_VDET) begin
				if (next_wstrb[0]) begin
					next_vdet = next_wdata[1:0];
				end
			end else if (next_waddr == `RSC_OFS_STATUS) begin
				next_bresp = 2'h0;
			end else begin
				next_bresp = 2'h2;
			end
		end
		if (axil_req.arvalid && !rvalid) begin
			next_rvalid = 1'b1;
			next_rresp = 2'h0;
			if (axil_req.araddr == `RSC_OFS_CTRL) begin
				next_rdata = ctrl;
			end else if (axil_req.araddr == `RSC_OFS_PIN_EN) begin
				next_rdata = pin_en_reg;
			end else if (axil_req.araddr == `RSC_OFS_VDET) begin
				next_rdata = {30'h0, vdet};
			end else if (axil_req.araddr == `RSC_OFS_STATUS) begin
				next_rdata = status;
			end else begin
				next_rdata = 32'h0000_0000;
				next_rresp = 2'h2;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			boot_done <= 1'b0;
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			waddr <= 8'h00;
			wdata <= 32'h0000_0000;
			wstrb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= 2'h0;
			ctrl <= `RSC_CTRL_RESET;
			pin_en_reg <= `RSC_PIN_EN_RESET;
			vdet <= `RSC_VDET_OFF;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= 2'h0;
		end else begin
			boot_done <= 1'b1;
			aw_hold <= next_aw_hold;
			w_hold <= next_w_hold;
			waddr <= next_waddr;
			wdata <= next_wdata;
			wstrb <= next_wstrb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			ctrl <= next_ctrl;
			pin_en_reg <= next_pin_en_reg;
			vdet <= next_vdet;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	assign low_voltage_detector_en = vdet[`RSC_VDET_LOW_BIT];
	assign high_voltage_detector_en = vdet[`RSC_VDET_HIGH_BIT];
	assign axil_rsp.awready = !aw_hold && !bvalid;
	assign axil_rsp.wready = !w_hold && !bvalid;
	assign axil_rsp.bvalid = bvalid;
	assign axil_rsp.bresp = bresp;
	assign axil_rsp.arready = !rvalid;
	assign axil_rsp.rvalid = rvalid;
	assign axil_rsp.rdata = rdata;
	assign axil_rsp.rresp = rresp;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	sequence s_enter_ph3_dest;
		$rose(state == ST_PH3) && (kind == K_DEST || kind == K_DEST_BIST);
	endsequence

	sequence s_ph3_wait;
		(state == ST_PH3) && !regtest_ok && !switching_regulator_test_done;
	endsequence

	a_pin_low_only: assert property (reset_pin_out == 1'b0)
		else $error("reset pin driven high");
	a_por_start: assert property ($rose(regulator_power_on_reset_n) |=> state == ST_PH1 ##1 state == ST_PH1)
		else $error("power-on release did not start phase one");
	a_short_no_bist: assert property (kind == K_FUNC_SHORT |-> state != ST_BIST && state != ST_PH2)
		else $error("short functional sequence ran self test");
	a_regtest_start: assert property (s_enter_ph3_dest |-> regtest_start ##1 !regtest_start)
		else $error("regulator self test not started in phase three");
	a_regtest_hold: assert property (s_ph3_wait ##0 (kind == K_DEST) ##0 regulator_power_on_reset_n && !destructive_event
		|=> state == ST_PH3)
		else $error("phase three ended before regulator test");
	a_run_entry: assert property ($rose(state == ST_RUN) |-> run_mode_entry && fetch_enable ##1 !run_mode_entry)
		else $error("run mode entry pulse wrong");
	a_extend_hold: assert property (state == ST_EXTEND && !reset_pin_in && regulator_power_on_reset_n
		&& !destructive_event |=> state == ST_EXTEND)
		else $error("sequence left extension while pin low");
	a_release_pin: assert property (state == ST_EXTEND || state == ST_RUN |-> reset_pin_oe_n)
		else $error("pin still driven after third phase");
	a_func_masked: assert property ((state == ST_PH1 || state == ST_PH3) && is_func && !pin_en[src]
		|-> reset_pin_oe_n)
		else $error("masked functional source drove the pin");
	a_vdet_boot: assert property ($rose(boot_done) && $past(external_regulation)
		|-> !low_voltage_detector_en && !high_voltage_detector_en)
		else $error("voltage detectors enabled in external regulation");
endmodule

//--- inc/reset_seq_defines.svh
// Purpose: constants of the reset sequence controller
// Assumes: sys_clk at 50 MHz
// Notes: times are in microseconds, cycle counts derive from them
//
// Overview of operation
// - Five sequences exist: destructive with and without self test, external long, functional long and short.
// - The short functional sequence never runs the built-in self test.
// - The sequence ends on entering run mode, where the first instruction is fetched.
// - Every destructive sequence starts the switching regulator self test inside the third phase.
// - Release of the regulator power-on-reset input starts the sequence in either regulation mode.
// - Only a low level is ever driven on the reset pin; the high level comes from the pull-up.
// - The pin assertion ends when the device stops driving low; it then rises by the pull-up.
// - The sequence is stretched while an outside generator holds the pin low past the third phase.
// - A functional sequence drives the pin low only if its source is enabled for the pin.
// - In external regulation the core supply voltage detectors start disabled; software may enable them.
`ifndef RESET_SEQ_DEFINES_SVH
`define RESET_SEQ_DEFINES_SVH

`define RSC_CLK_MHZ 50
`define RSC_PH1_US 10
`define RSC_PH2_US 10
`define RSC_PH3_US 10
`define RSC_BIST_US 100
`define RSC_PH1_CYC (`RSC_PH1_US * `RSC_CLK_MHZ)
`define RSC_PH2_CYC (`RSC_PH2_US * `RSC_CLK_MHZ)
`define RSC_PH3_CYC (`RSC_PH3_US * `RSC_CLK_MHZ)
`define RSC_BIST_CYC (`RSC_BIST_US * `RSC_CLK_MHZ)

`define RSC_OFS_CTRL 8'h00
`define RSC_OFS_PIN_EN 8'h04
`define RSC_OFS_VDET 8'h08
`define RSC_OFS_STATUS 8'h0C

`define RSC_CTRL_BIST_BIT 0
`define RSC_VDET_LOW_BIT 0
`define RSC_VDET_HIGH_BIT 1

`define RSC_CTRL_RESET 32'h0000_0001
`define RSC_PIN_EN_RESET 32'hFFFF_FFFF
`define RSC_VDET_ON 2'h3
`define RSC_VDET_OFF 2'h0

`endif

//--- inc/reset_seq_pkg.sv
// Purpose: types of the reset sequence controller
// Assumes: nothing
// Notes: one-hot state codes
package reset_seq_pkg;
	typedef enum logic [6:0] {
		ST_POR = 7'h01,
		ST_PH1 = 7'h02,
		ST_PH2 = 7'h04,
		ST_BIST = 7'h08,
		ST_PH3 = 7'h10,
		ST_EXTEND = 7'h20,
		ST_RUN = 7'h40
	} seq_state_e;

	typedef enum logic [2:0] {
		K_DEST_BIST = 3'h0,
		K_DEST = 3'h1,
		K_EXT_LONG = 3'h2,
		K_FUNC_LONG = 3'h3,
		K_FUNC_SHORT = 3'h4
	} seq_kind_e;

	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} axil_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axil_rsp_s;
endpackage
